//--- design/eienf_top.sv
// Purpose: Noise filter and edge detector for external interrupt channels two and three
// Assumes: Single clock clk is the gear clock; lfClk is sampled as a pin
// Notes: Avalon-MM slave, one wait state on every access
// Summary of operation
// [R1] Channel two edge code 00 rising, 01 falling, 10 both, 11 no request.
// [R2] Channel three uses the same edge coding.
// [R3] Channel two samples at clk, /4, /8, /16; slow mode samples lfClk/4.
// [R4] Channel three sampling rates match channel two.
// [R5] Level flag holds filtered level at the last request; zero initially.
// [R6] Config bits 7..5 read zero; level read-only; select fields writable.
// [R7] Mode changes may cause spurious requests; software masks first.
// [R8] Config writes may cause spurious requests; software masks first.
// [R9] Software waits twelve low clock periods after entering slow mode.
// [R10] Software waits two clk plus three sample periods after leaving slow mode.
// [R11] Level flag is refreshed on every request of the channel.
// [R12] Disabled channel stops sampling and ignores config writes.
// [R13] Fast mode rejects under two samples, accepts three agreeing samples.
// [R14] Reset clears all config fields and level flags.
`timescale 1ns/1ps
`include "eienf_params.svh"
`default_nettype none
module eienf_top import eienf_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [13:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Pins
	input wire logic [1:0] extIrqPin,
	input wire logic lfClk,
	// Requests to the interrupt latch
	output logic [1:0] irqReq,
	output logic irq
);
	function automatic logic sampleTick(input eienf_rate_t rate, input logic [3:0] presc);
		logic t;
		t = 1'b0;
		unique case (rate)
			RATE_DIV1: t = 1'b1;
			RATE_DIV4: t = (presc[1:0] == 2'h0);
			RATE_DIV8: t = (presc[2:0] == 3'h0);
			RATE_DIV16: t = (presc == 4'h0);
		endcase
		return t;
	endfunction

	function automatic logic edgeHit(input eienf_edge_t sel, input logic rise, input logic fall);
		logic h;
		h = 1'b0;
		unique case (sel)
			EDGE_RISE: h = rise;
			EDGE_FALL: h = fall;
			EDGE_BOTH: h = rise | fall;
			EDGE_RSVD: h = 1'b0;
		endcase
		return h;
	endfunction

	function automatic logic isReg(input logic [13:0] addr, input logic [11:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	logic [1:0] pinS1_q, pinS2_q, pinS3_q, pinStable_q, pinStable_d;
	logic lfS1_q, lfS2_q, lfS3_q, lfStable_q, lfStable_d, lfPrev_q, lfPrev_d;
	logic [1:0] lfDiv_q, lfDiv_d;
	logic [3:0] presc_q, presc_d;
	logic [2:0] hist_q [2];
	logic [2:0] hist_d [2];
	logic [1:0] filt_q, filt_d, req_q, req_d, tick, hit;
	logic lfTick, slowMode;
	eienf_cfg_t cfg_q [2];
	eienf_cfg_t cfg_d [2];
	logic [2:0] ctrl_q, ctrl_d;
	logic [1:0] stat_q, stat_d, mask_q, mask_d, chEn;
	logic irq_q, irq_d, wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	eienf_bus_t bus_q, bus_d;
	logic wrLow;

	assign chEn = {ctrl_q[`EIENF_CTRL_EN3], ctrl_q[`EIENF_CTRL_EN2]};
	assign slowMode = ctrl_q[`EIENF_CTRL_SLOW];

	// Pin sync, sampling clocks, noise filter and edge detect
	always_comb begin
		pinStable_d = pinStable_q;
		for (int i = 0; i < 2; i++) begin
			if (pinS2_q[i] == pinS3_q[i]) begin
				pinStable_d[i] = pinS3_q[i];
			end
		end
		lfStable_d = (lfS2_q == lfS3_q) ? lfS3_q : lfStable_q;
		lfPrev_d = lfStable_q;
		lfDiv_d = lfDiv_q;
		lfTick = 1'b0;
		if (lfStable_q && !lfPrev_q) begin
			lfDiv_d = lfDiv_q + 2'h1;
			lfTick = (lfDiv_q == `EIENF_LF_DIV_LAST);
		end
		presc_d = presc_q + 4'h1;
		for (int c = 0; c < 2; c++) begin
			// Disabled channel freezes its sampler [R12]
			tick[c] = chEn[c] && (slowMode ? lfTick : sampleTick(cfg_q[c].rate, presc_q)); // [R3] [R4]
			hist_d[c] = tick[c] ? {hist_q[c][1:0], pinStable_q[c]} : hist_q[c];
			filt_d[c] = filt_q[c];
			// Three agreeing samples fast, two slow [R13]
			if (chEn[c]) begin
				if (slowMode) begin
					if (hist_q[c][1:0] == 2'b11) filt_d[c] = 1'b1;
					if (hist_q[c][1:0] == 2'b00) filt_d[c] = 1'b0;
				end else begin
					if (hist_q[c] == 3'b111) filt_d[c] = 1'b1;
					if (hist_q[c] == 3'b000) filt_d[c] = 1'b0;
				end
			end
			// Mode or config changes are not guarded here [R7] [R8]
			hit[c] = edgeHit(cfg_q[c].edgeSel, filt_d[c] & ~filt_q[c], ~filt_d[c] & filt_q[c]); // [R1] [R2]
			req_d[c] = hit[c];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinS1_q <= 2'h0;
			pinS2_q <= 2'h0;
			pinS3_q <= 2'h0;
			pinStable_q <= 2'h0;
			lfS1_q <= 1'b0;
			lfS2_q <= 1'b0;
			lfS3_q <= 1'b0;
			lfStable_q <= 1'b0;
			lfPrev_q <= 1'b0;
			lfDiv_q <= 2'h0;
			presc_q <= 4'h0;
			hist_q[0] <= 3'h0;
			hist_q[1] <= 3'h0;
			filt_q <= 2'h0;
			req_q <= 2'h0;
		end else begin
			pinS1_q <= extIrqPin;
			pinS2_q <= pinS1_q;
			pinS3_q <= pinS2_q;
			pinStable_q <= pinStable_d;
			lfS1_q <= lfClk;
			lfS2_q <= lfS1_q;
			lfS3_q <= lfS2_q;
			lfStable_q <= lfStable_d;
			lfPrev_q <= lfPrev_d;
			lfDiv_q <= lfDiv_d;
			presc_q <= presc_d;
			hist_q[0] <= hist_d[0];
			hist_q[1] <= hist_d[1];
			filt_q <= filt_d;
			req_q <= req_d;
		end
	end

	// Register file and Avalon slave
	always_comb begin
		bus_d = bus_q;
		wait_d = wait_q;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		cfg_d[0] = cfg_q[0];
		cfg_d[1] = cfg_q[1];
		wrLow = 1'b0;
		unique case (bus_q)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_d = BUS_ACK;
					wait_d = 1'b0;
					rdata_d = 32'h0000_0000;
					if (isReg(avs_address, `EIENF_IDX_CFG2)) begin
						rdata_d[4:0] = cfg_q[0][4:0]; // [R6]
					end
					if (isReg(avs_address, `EIENF_IDX_CFG3)) begin
						rdata_d[4:0] = cfg_q[1][4:0]; // [R6]
					end
					if (isReg(avs_address, `EIENF_IDX_CTRL)) rdata_d[2:0] = ctrl_q;
					if (isReg(avs_address, `EIENF_IDX_STAT)) rdata_d[1:0] = stat_q;
					if (isReg(avs_address, `EIENF_IDX_MASK)) rdata_d[1:0] = mask_q;
				end
			end
			BUS_ACK: begin
				bus_d = BUS_IDLE;
				wait_d = 1'b1;
				wrLow = avs_write && avs_byteenable[0];
			end
		endcase
		if (wrLow) begin
			if (isReg(avs_address, `EIENF_IDX_CTRL)) ctrl_d = avs_writedata[2:0];
			if (isReg(avs_address, `EIENF_IDX_MASK)) mask_d = avs_writedata[1:0];
			// Only select fields are writable, and only while enabled [R6] [R12]
			if (isReg(avs_address, `EIENF_IDX_CFG2) && chEn[0]) begin
				cfg_d[0].edgeSel = eienf_edge_t'(avs_writedata[3:2]);
				cfg_d[0].rate = eienf_rate_t'(avs_writedata[1:0]);
			end
			if (isReg(avs_address, `EIENF_IDX_CFG3) && chEn[1]) begin
				cfg_d[1].edgeSel = eienf_edge_t'(avs_writedata[3:2]);
				cfg_d[1].rate = eienf_rate_t'(avs_writedata[1:0]);
			end
		end
		for (int c = 0; c < 2; c++) begin
			if (hit[c]) cfg_d[c].level = filt_d[c]; // [R5] [R11]
		end
		stat_d = stat_q;
		if (wrLow && isReg(avs_address, `EIENF_IDX_STAT)) stat_d = stat_q & ~avs_writedata[1:0];
		stat_d = stat_d | hit;
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_q <= BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			ctrl_q <= `EIENF_RST_CTRL;
			mask_q <= `EIENF_RST_IRQ;
			stat_q <= `EIENF_RST_IRQ;
			irq_q <= 1'b0;
			cfg_q[0] <= `EIENF_RST_CFG; // [R14]
			cfg_q[1] <= `EIENF_RST_CFG; // [R14]
		end else begin
			bus_q <= bus_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			irq_q <= irq_d;
			cfg_q[0] <= cfg_d[0];
			cfg_q[1] <= cfg_d[1];
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign irqReq = req_q;
	assign irq = irq_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_rsvd_read_zero: assert property (!wait_q |-> rdata_q[7:5] == 3'h0) // [R6]
		else $error("reserved config bits read nonzero");
	chk_ch2_rise_req: assert property (chEn[0] && cfg_q[0].edgeSel == EDGE_RISE &&
		!filt_q[0] ##1 filt_q[0] |-> req_q[0]) // [R1]
		else $error("channel two rising edge gave no request");
	chk_ch2_fall_none: assert property (cfg_q[0].edgeSel == EDGE_FALL &&
		!filt_q[0] ##1 filt_q[0] |-> !req_q[0]) // [R1]
		else $error("channel two falling mode requested on rising edge");
	chk_ch3_both_req: assert property (cfg_q[1].edgeSel == EDGE_BOTH ##1
		$changed(filt_q[1]) |-> req_q[1]) // [R2]
		else $error("channel three both-edge mode missed an edge");
	chk_rsvd_no_req: assert property ($past(cfg_q[1].edgeSel) == EDGE_RSVD |-> !req_q[1]) // [R2]
		else $error("reserved edge code raised a request");
	chk_level_capture: assert property (req_q[0] |-> cfg_q[0].level == filt_q[0]) // [R5] [R11]
		else $error("level flag not captured at request");
	chk_disabled_frozen: assert property (!chEn[1] |=> $stable(filt_q[1]) && !req_q[1]) // [R12]
		else $error("disabled channel changed filter state");
	chk_write_blocked: assert property (!chEn[0] && !wait_q && avs_write &&
		isReg(avs_address, `EIENF_IDX_CFG2) |=> $stable(cfg_q[0].edgeSel)) // [R12]
		else $error("write to disabled channel took effect");
	chk_filter_agree: assert property (!slowMode && $rose(filt_q[0]) |->
		$past(hist_q[0]) == 3'b111) // [R13]
		else $error("filter flipped without three agreeing samples");
	chk_div16_rate: assert property (!slowMode && chEn[0] && cfg_q[0].rate == RATE_DIV16 &&
		tick[0] |-> presc_q == 4'h0 ##1 (slowMode || !tick[0]) [*8]) // [R3]
		else $error("divide by sixteen sampling too fast");
	chk_slow_rate: assert property (slowMode && tick[1] |-> lfTick) // [R4]
		else $error("slow mode sampled off the low clock tick");
	chk_irq_level: assert property ((|(stat_q & mask_q)) |-> irq_q) // [R1] [R2]
		else $error("unmasked status without interrupt");
endmodule
`default_nettype wire

//--- include/eienf_params.svh
// Purpose: Offsets, field positions, reset values and counts of the edge/noise filter block
// Assumes: Included by bare name
// Notes: Byte address of a register is four times its index
`ifndef EIENF_PARAMS_SVH
`define EIENF_PARAMS_SVH
`define EIENF_IDX_CFG2 12'h0fd9
`define EIENF_IDX_CFG3 12'h0fda
`define EIENF_IDX_CTRL 12'h0fe0
`define EIENF_IDX_STAT 12'h0fe1
`define EIENF_IDX_MASK 12'h0fe2
`define EIENF_RST_CFG 8'h00
`define EIENF_RST_CTRL 3'h0
`define EIENF_RST_IRQ 2'h0
`define EIENF_CTRL_EN2 0
`define EIENF_CTRL_EN3 1
`define EIENF_CTRL_SLOW 2
`define EIENF_LF_DIV_LAST 2'h3
`endif

//--- include/eienf_pkg.sv
// Purpose: Types of the edge/noise filter block
// Assumes: Nothing
// Notes: Channel 0 of each array is channel two, 1 is channel three
package eienf_pkg;
	typedef enum logic [1:0] {
		EDGE_RISE = 2'b00,
		EDGE_FALL = 2'b01,
		EDGE_BOTH = 2'b10,
		EDGE_RSVD = 2'b11
	} eienf_edge_t;
	typedef enum logic [1:0] {
		RATE_DIV1 = 2'b00,
		RATE_DIV4 = 2'b01,
		RATE_DIV8 = 2'b10,
		RATE_DIV16 = 2'b11
	} eienf_rate_t;
	typedef struct packed {
		logic [2:0] zero;
		logic level;
		eienf_edge_t edgeSel;
		eienf_rate_t rate;
	} eienf_cfg_t;
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} eienf_bus_t;
endpackage

//--- sim/eienf_pin_model.sv
// Purpose: Board side of the two external interrupt pins and the low-frequency clock
// Assumes: The testbench commands the pin levels
// Notes: The low-frequency clock runs free, as a board oscillator does
`timescale 1ns/1ps
`default_nettype none
module eienf_pin_model #(parameter int LF_HALF_NS = 40) (
	// Commanded levels
	input wire logic [1:0] levelCmd,
	// Pins
	output logic [1:0] extIrqPin,
	output logic lfClk
);
	assign extIrqPin = levelCmd;
	initial begin
		lfClk = 1'b0;
		forever #(LF_HALF_NS) lfClk = ~lfClk;
	end
endmodule
`default_nettype wire

//--- sim/eienf_top_tb.sv
// Purpose: Self-checking bench of the edge and noise filter block
// Assumes: Avalon-MM master tasks, pin model on the far side
// Notes: Low clock period is 8 gear cycles
`timescale 1ns/1ps
`include "eienf_params.svh"
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", nm, ex, got); end end
module eienf_top_tb import eienf_pkg::*; ;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, lfClk;
	logic [13:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [1:0] irqReq, extIrqPin, levelCmd;
	logic [7:0] rd;
	logic expLvl;
	eienf_cfg_t cfg;
	int n_fail, n_checks, cyc, base;
	int reqCnt [2];
	eienf_top dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .extIrqPin(extIrqPin), .lfClk(lfClk),
		.irqReq(irqReq), .irq(irq));
	eienf_pin_model pin_u (.levelCmd(levelCmd), .extIrqPin(extIrqPin), .lfClk(lfClk));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		for (int c = 0; c < 2; c++) reqCnt[c] += (irqReq[c] === 1'b1);
		if (cyc == 30000) begin
			n_fail++;
			end_sim;
		end
	end
	// One Avalon access; read data lands in rd
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= {24'h00_0000, wd};
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata[7:0];
		`CHK("readdata upper", 24'h00_0000, avs_readdata[31:8])
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic setPin(input int c, input logic v, input int n);
		@(posedge clk);
		levelCmd[c] <= v;
		repeat (n) @(posedge clk);
	endtask
	initial begin
		sys_rst = 1'b1;
		{avs_address, avs_read, avs_write, avs_writedata, levelCmd} = '0;
		avs_byteenable = 4'hf;
		n_fail = 0;
		n_checks = 0;
		cyc = 0;
		reqCnt = '{0, 0};
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		bus(0, `EIENF_IDX_CFG2, 8'h00); `CHK("cfg2 reset", 8'h00, rd)
		bus(0, `EIENF_IDX_CFG3, 8'h00); `CHK("cfg3 reset", 8'h00, rd)
		bus(1, `EIENF_IDX_CFG2, 8'h0d);
		bus(0, `EIENF_IDX_CFG2, 8'h00); `CHK("cfg2 disabled", 8'h00, rd)
		bus(1, `EIENF_IDX_CTRL, 8'h03);
		bus(1, `EIENF_IDX_MASK, 8'h03);
		bus(1, `EIENF_IDX_CFG2, 8'hff);
		bus(0, `EIENF_IDX_CFG2, 8'h00); `CHK("cfg2 fields", 8'h0f, rd)
		bus(0, 12'h0fdb, 8'h00); `CHK("unmapped", 8'h00, rd)
		for (int c = 0; c < 2; c++) begin
			expLvl = 1'b0;
			for (int e = 0; e < 4; e++) begin
				bus(1, 12'(`EIENF_IDX_CFG2 + c), {4'h0, e[1:0], e[1:0]});
				bus(1, `EIENF_IDX_STAT, 8'h03);
				base = reqCnt[c];
				setPin(c, 1'b1, 40);
				if (e == 0 || e == 2) expLvl = 1'b1;
				bus(0, 12'(`EIENF_IDX_CFG2 + c), 8'h00);
				cfg = rd;
				`CHK("level rise", expLvl, cfg.level)
				setPin(c, 1'b0, 40);
				if (e == 1 || e == 2) expLvl = 1'b0;
				bus(0, 12'(`EIENF_IDX_CFG2 + c), 8'h00);
				cfg = rd;
				`CHK("level fall", expLvl, cfg.level)
				`CHK("edge count", (e < 2) ? 1 : (e == 2) ? 2 : 0, reqCnt[c] - base)
				`CHK("irq set", 1'(e != 3), irq)
				bus(1, `EIENF_IDX_STAT, 8'h03);
				bus(0, `EIENF_IDX_STAT, 8'h00); `CHK("status clear", 8'h00, rd)
				`CHK("irq clear", 1'b0, irq)
			end
			bus(1, 12'(`EIENF_IDX_CFG2 + c), 8'h00);
			base = reqCnt[c];
			setPin(c, 1'b1, 1);
			setPin(c, 1'b0, 30); `CHK("short pulse", base, reqCnt[c])
			bus(1, 12'(`EIENF_IDX_CFG2 + c), 8'h03);
			setPin(c, 1'b1, 20);
			setPin(c, 1'b0, 80); `CHK("div16 reject", base, reqCnt[c])
			setPin(c, 1'b1, 70);
			setPin(c, 1'b0, 80); `CHK("div16 accept", base + 1, reqCnt[c])
		end
		bus(1, `EIENF_IDX_MASK, 8'h00);
		bus(1, `EIENF_IDX_CTRL, 8'h07);
		repeat (96) @(posedge clk);
		bus(1, `EIENF_IDX_STAT, 8'h03);
		bus(1, `EIENF_IDX_CFG2, 8'h00);
		base = reqCnt[0];
		setPin(0, 1'b1, 16);
		setPin(0, 1'b0, 150); `CHK("slow reject", base, reqCnt[0])
		setPin(0, 1'b1, 200);
		setPin(0, 1'b0, 150); `CHK("slow accept", base + 1, reqCnt[0])
		bus(0, `EIENF_IDX_STAT, 8'h00); `CHK("masked status", 8'h01, rd)
		`CHK("masked irq", 1'b0, irq)
		bus(1, `EIENF_IDX_MASK, 8'h01);
		repeat (2) @(posedge clk);
		`CHK("unmasked irq", 1'b1, irq)
		bus(1, `EIENF_IDX_CTRL, 8'h03);
		// Two clk plus three samples of the slowest channel, divide by sixteen
		repeat (50) @(posedge clk);
		bus(1, `EIENF_IDX_STAT, 8'h03);
		bus(0, `EIENF_IDX_STAT, 8'h00); `CHK("resume status", 8'h00, rd)
		end_sim;
	end
endmodule
`default_nettype wire
